// File: verilog/flash_host_pkg.sv
// Notes on behaviour
// R01: Array holds 11 sectors; each is the erase and protect unit.
// R02: Four boot sectors of 8 to 32 KB, seven of 64 KB.
// R03: Top-boot map: 64 KB regions, then 32, 8, 8, 16 KB at top.
// R04: Bottom-boot map: 16, 8, 8, 32 KB at bottom, then 64 KB regions.
// R05: Byte mode uses top data pin as address LSB; word mode 18 bits.
// R06: Command latches sit outside the memory map.
// R07: Read: chip select and output enable low, write strobe high, reset off.
// R08: Byte mode leaves data lines 14..8 floating in read and write.
// R09: After reset the device reads array without any command.
// R10: Busy or suspended-sector reads return status, not array data.
// R11: Device returns to read-array by itself when an algorithm ends.
// R12: Host resets to leave timeout or identification states.
// R13: Write: chip select and write strobe low, output enable high.
// R14: Address is captured on the later falling strobe edge.
// R15: Data is captured on the earlier rising strobe edge.
// R16: Output enable high floats the whole data bus.
// R17: Standby floats data regardless of output enable.
// R18: Elevated address bit 9 reads maker code at 00, part code at 01.
// R19: Elevated address bit 9 at low address 02 reads sector protect state.
// R20: Protect, unprotect and temporary unprotect need elevated pin levels.
// R21: Each elevated level is a separate digital detect signal.
package flash_host_pkg;
   localparam int          ADDR_W        = 18;
   localparam int          DATA_W        = 16;
   localparam int          NUM_SECTORS   = 11;
   // Strobe phase lengths in cycles of the 8 ns clock
   localparam int          T_SETUP_NS    = 20;
   localparam int          T_PULSE_NS    = 60;
   localparam int          T_HOLD_NS     = 20;
   localparam int          CLK_NS        = 8;
   localparam logic [3:0]  SETUP_CYC     = 4'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  PULSE_CYC     = 4'((T_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0]  HOLD_CYC      = 4'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
   // Identification low addresses
   localparam logic [7:0]  ID_MAKER_ADDR = 8'h00;
   localparam logic [7:0]  ID_PART_ADDR  = 8'h01;
   localparam logic [7:0]  ID_PROT_ADDR  = 8'h02;
   localparam logic [7:0]  PROT_YES      = 8'h01;
   // Operation codes of the host command port
   localparam logic [2:0]  OP_READ       = 3'h0;
   localparam logic [2:0]  OP_WRITE      = 3'h1;
   localparam logic [2:0]  OP_ID_READ    = 3'h2;
   localparam logic [2:0]  OP_PROTECT    = 3'h3;
   localparam logic [2:0]  OP_UNPROTECT  = 3'h4;
   localparam logic [2:0]  OP_RESET      = 3'h5;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_SETUP = 5'h02,
      ST_PULSE = 5'h04,
      ST_HOLD  = 5'h08,
      ST_DONE  = 5'h10
   } phase_type;

   // Sector index from word address for either boot variant
   function automatic logic [3:0] sector_of(input logic [17:0] a, input logic top_boot);
      logic [3:0] s;
      s = 4'h0;
      if (top_boot) begin
         if (a[17:15] != 3'h7)
            s = {1'b0, a[17:15]};
         else if (!a[14])
            s = 4'h7;
         else if (a[13])
            s = 4'ha;
         else
            s = a[12] ? 4'h9 : 4'h8;
      end else begin
         if (a[17:15] != 3'h0)
            s = 4'(a[17:15]) + 4'h3;
         else if (a[14])
            s = 4'h3;
         else if (!a[13])
            s = 4'h0;
         else
            s = a[12] ? 4'h2 : 4'h1;
      end
      return s;
   endfunction
endpackage

// File: verilog/flash_host.sv
`timescale 1ns/10ps
module flash_host #(
   parameter bit TOP_BOOT = 1'b1
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   // Command port
   input  wire logic        req_valid,
   input  wire logic [2:0]  req_op,
   input  wire logic [18:0] req_addr,
   input  wire logic [15:0] req_wdata,
   input  wire logic        req_byte_mode,
   output logic             req_ready,
   output logic             rsp_valid,
   output logic [15:0]      rsp_rdata,
   output logic [3:0]       rsp_sector,
   output logic             rsp_protected,
   // Flash pins
   output logic [17:0]      addr_pin,
   output logic             chip_sel_b,
   output logic             out_en_b,
   output logic             wr_en_b,
   output logic             reset_b,
   output logic             byte_b,
   output logic [15:0]      dq_out,
   output logic [15:0]      dq_oe,
   input  wire logic [15:0] dq_in,
   // Elevated-level drives
   output logic             a9_elevated,
   output logic             chip_sel_elevated,
   output logic             out_en_elevated,
   output logic             reset_elevated
);
   flash_host_pkg::phase_type phase_r;
   logic [3:0]  cnt_r;
   logic [2:0]  op_r;
   logic        bm_r;
   logic        addr_lsb_r;
   logic [15:0] req_wdata_r;

   // Phase sequencer for one strobe cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         phase_r <= flash_host_pkg::ST_IDLE;
         cnt_r   <= 4'h0;
      end else begin
         case (phase_r)
            flash_host_pkg::ST_IDLE: begin
               if (req_valid) begin
                  phase_r <= flash_host_pkg::ST_SETUP;
                  cnt_r   <= flash_host_pkg::SETUP_CYC;
               end
            end
            flash_host_pkg::ST_SETUP: begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1) begin
                  phase_r <= flash_host_pkg::ST_PULSE;
                  cnt_r   <= flash_host_pkg::PULSE_CYC;
               end
            end
            flash_host_pkg::ST_PULSE: begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1) begin
                  phase_r <= flash_host_pkg::ST_HOLD;
                  cnt_r   <= flash_host_pkg::HOLD_CYC;
               end
            end
            flash_host_pkg::ST_HOLD: begin
               cnt_r <= cnt_r - 4'h1;
               if (cnt_r == 4'h1)
                  phase_r <= flash_host_pkg::ST_DONE;
            end
            default: begin
               phase_r <= flash_host_pkg::ST_IDLE;
               cnt_r   <= 4'h0;
            end
         endcase
      end
   end

   // Request capture; address and mode held steady for the whole cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         op_r     <= flash_host_pkg::OP_READ;
         bm_r     <= 1'b0;
         addr_pin <= 18'h0;
         byte_b   <= 1'b1;
      end else if (phase_r == flash_host_pkg::ST_IDLE && req_valid) begin
         op_r     <= req_op;
         bm_r     <= req_byte_mode;
         addr_pin <= req_addr[18:1];                  // [R05]
         byte_b   <= !req_byte_mode;                  // [R05]
      end
   end

   // Strobes: chip select spans setup to hold except for a reset request, active strobe only in pulse
   // so the device sees address stable before and data stable after [R14] [R15]
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         chip_sel_b <= 1'b1;
         out_en_b   <= 1'b1;
         wr_en_b    <= 1'b1;
         reset_b    <= 1'b0;
      end else begin
         reset_b    <= !(phase_r != flash_host_pkg::ST_IDLE && phase_r != flash_host_pkg::ST_DONE
                         && op_r == flash_host_pkg::OP_RESET);               // [R12]
         chip_sel_b <= !(phase_r == flash_host_pkg::ST_SETUP || phase_r == flash_host_pkg::ST_PULSE
                         || phase_r == flash_host_pkg::ST_HOLD) || op_r == flash_host_pkg::OP_RESET;
         out_en_b   <= !(phase_r == flash_host_pkg::ST_PULSE
                         && (op_r == flash_host_pkg::OP_READ || op_r == flash_host_pkg::OP_ID_READ)); // [R07]
         wr_en_b    <= !(phase_r == flash_host_pkg::ST_PULSE && op_r == flash_host_pkg::OP_WRITE);    // [R13]
      end
   end

   // Data drive: low byte, plus address LSB on the top pin in byte mode
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         dq_out <= 16'h0;
         dq_oe  <= 16'h0;
      end else if (phase_r == flash_host_pkg::ST_SETUP && cnt_r == flash_host_pkg::SETUP_CYC) begin
         dq_out <= bm_r ? {addr_lsb_r, 7'h0, req_wdata_r[7:0]} : req_wdata_r;
         if (op_r == flash_host_pkg::OP_WRITE)
            dq_oe <= bm_r ? 16'h80ff : 16'hffff;   // [R13] [R08]
         else
            dq_oe <= bm_r ? 16'h8000 : 16'h0000;   // Reads leave lines 14..0 to the device, all lines in word mode [R16]
      end else if (phase_r == flash_host_pkg::ST_DONE || phase_r == flash_host_pkg::ST_IDLE) begin
         dq_oe <= 16'h0;
      end
   end

   // Byte address LSB and write data, latched when a request is taken
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         addr_lsb_r  <= 1'b0;
         req_wdata_r <= 16'h0;
      end else if (phase_r == flash_host_pkg::ST_IDLE && req_valid) begin
         addr_lsb_r  <= req_addr[0];
         req_wdata_r <= req_wdata;
      end
   end

   // Elevated-level drives for identification and protect operations [R20] [R21]
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         a9_elevated       <= 1'b0;
         chip_sel_elevated <= 1'b0;
         out_en_elevated   <= 1'b0;
         reset_elevated    <= 1'b0;
      end else begin
         a9_elevated       <= phase_r != flash_host_pkg::ST_IDLE && phase_r != flash_host_pkg::ST_DONE
                              && (op_r == flash_host_pkg::OP_ID_READ || op_r == flash_host_pkg::OP_PROTECT
                              || op_r == flash_host_pkg::OP_UNPROTECT);     // [R18] [R19]
         out_en_elevated   <= phase_r == flash_host_pkg::ST_PULSE
                              && (op_r == flash_host_pkg::OP_PROTECT || op_r == flash_host_pkg::OP_UNPROTECT);
         chip_sel_elevated <= phase_r == flash_host_pkg::ST_PULSE && op_r == flash_host_pkg::OP_UNPROTECT;
         reset_elevated    <= 1'b0;   // Temporary unprotect not driven by this port
      end
   end

   // Answer: sample the bus at the last pulse cycle, report sector decode
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rsp_valid     <= 1'b0;
         rsp_rdata     <= 16'h0;
         rsp_sector    <= 4'h0;
         rsp_protected <= 1'b0;
         req_ready     <= 1'b0;
      end else begin
         rsp_valid  <= phase_r == flash_host_pkg::ST_HOLD && cnt_r == 4'h1;
         req_ready  <= phase_r == flash_host_pkg::ST_IDLE && !req_valid;
         rsp_sector <= flash_host_pkg::sector_of(addr_pin, TOP_BOOT);       // [R01] [R02] [R03] [R04]
         if (phase_r == flash_host_pkg::ST_PULSE && cnt_r == 4'h1) begin
            rsp_rdata     <= bm_r ? {8'h0, dq_in[7:0]} : dq_in;             // [R07]
            rsp_protected <= op_r == flash_host_pkg::OP_ID_READ && addr_pin[7:0] == flash_host_pkg::ID_PROT_ADDR
                             && dq_in[7:0] == flash_host_pkg::PROT_YES;     // [R19]
         end
      end
   end

   // Both strobes stay high for the setup span after chip select falls
   sequence strobes_off_3;
      (out_en_b && wr_en_b) [*3];
   endsequence
   // Chip select stays low for the hold span after a strobe rises,
   // so the strobe edge, not chip select, is the one that latches data
   sequence sel_held_3;
      !chip_sel_b [*3];
   endsequence

   // Read strobes never overlap a write strobe
   AST_NO_OVERLAP: assert property (@(posedge core_clk) disable iff (!rst_b) // [R07]
      !(!out_en_b && !wr_en_b)) else $error("read and write strobes overlap");
   // Address must not move while chip select is low
   AST_ADDR_STABLE: assert property (@(posedge core_clk) disable iff (!rst_b) // [R14]
      (!chip_sel_b && $past(!chip_sel_b)) |-> $stable(addr_pin)) else $error("address moved");
   // Write strobe only inside chip select
   AST_WE_IN_CS: assert property (@(posedge core_clk) disable iff (!rst_b) // [R13]
      !wr_en_b |-> !chip_sel_b) else $error("write strobe outside select");
   // Data stays driven one cycle after write strobe rises
   AST_DATA_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b) // [R15]
      $rose(wr_en_b) |-> dq_oe[0]) else $error("data dropped at strobe rise");
   // Byte mode keeps lines 14..8 undriven
   AST_BYTE_HIZ: assert property (@(posedge core_clk) disable iff (!rst_b) // [R08]
      !byte_b |-> dq_oe[14:8] == 7'h0) else $error("upper lines driven in byte mode");
   // Never drive lines 7..0 while output enable is low
   AST_NO_FIGHT: assert property (@(posedge core_clk) disable iff (!rst_b) // [R16]
      !out_en_b |-> dq_oe[7:0] == 8'h0) else $error("bus contention");
   // Write pulse lasts its full width
   AST_PULSE_W: assert property (@(posedge core_clk) disable iff (!rst_b) // [R13]
      $fell(wr_en_b) |-> !wr_en_b [*8]) else $error("short write pulse");
   // Identification reads hold address bit 9 elevated around output enable
   AST_ID_A9: assert property (@(posedge core_clk) disable iff (!rst_b) // [R18]
      (!out_en_b && op_r == flash_host_pkg::OP_ID_READ) |-> a9_elevated) else $error("id read without level");
   // Address settles before either strobe falls
   AST_STROBE_SETUP: assert property (@(posedge core_clk) disable iff (!rst_b) // [R14]
      $fell(chip_sel_b) |-> strobes_off_3) else $error("strobe inside setup span");
   // Chip select outlasts the strobe by the hold span
   AST_SEL_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b) // [R15]
      ($rose(wr_en_b) || $rose(out_en_b)) |-> sel_held_3) else $error("select dropped inside hold span");
   // A device reset pulse keeps every strobe quiet
   AST_RESET_QUIET: assert property (@(posedge core_clk) disable iff (!rst_b) // [R12]
      !reset_b |-> (chip_sel_b && out_en_b && wr_en_b)) else $error("strobe active during device reset");
   // Unprotect raises select only together with output enable and bit 9 levels
   AST_UNPROT_LEVELS: assert property (@(posedge core_clk) disable iff (!rst_b) // [R20]
      chip_sel_elevated |-> (out_en_elevated && a9_elevated)) else $error("unprotect levels incomplete");
   // Protect pulse needs select low and bit 9 elevated
   AST_PROT_SEL: assert property (@(posedge core_clk) disable iff (!rst_b) // [R20]
      (out_en_elevated && !chip_sel_elevated) |-> (!chip_sel_b && a9_elevated)) else $error("protect without select");
endmodule

// File: bench/flash_dev_model.sv
`timescale 1ns/10ps
module flash_dev_model #(
   parameter logic [15:0] MAKER_CODE = 16'h00c5, // Arbitrary value
   parameter logic [15:0] PART_CODE  = 16'h3a5c  // Arbitrary value
) (
   // Clock for the floating pattern
   input  wire logic        core_clk,
   // Device pins
   input  wire logic [17:0] addr_pin,
   input  wire logic        chip_sel_b,
   input  wire logic        out_en_b,
   input  wire logic        wr_en_b,
   input  wire logic        reset_b,
   input  wire logic        byte_b,
   input  wire logic [15:0] dq_out,
   input  wire logic [15:0] dq_oe,
   input  wire logic        a9_elevated,
   input  wire logic        chip_sel_elevated,
   input  wire logic        out_en_elevated,
   input  wire logic        reset_elevated,
   // Resolved data bus
   output logic [15:0]      dq_in
);
   logic [15:0] mem [256];
   logic        prot [64];
   logic [15:0] flt;
   logic [15:0] rd;
   logic [15:0] dev_oe;
   logic [8:0]  wa;
   logic        we_act;
   logic        rd_act;
   logic        a_m1;

   // Erased array, nothing protected; reads array with no command
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
      for (int i = 0; i < 64; i++) prot[i] = 1'b0;
      flt = 16'h5555;
   end
   // Undriven lines toggle so a stale value never passes for data
   always @(posedge core_clk) flt <= ~flt;
   assign a_m1   = dq_oe[15] ? dq_out[15] : flt[15];
   assign we_act = !chip_sel_b && !wr_en_b && out_en_b && reset_b;
   assign rd_act = !chip_sel_b && !out_en_b && wr_en_b && reset_b;
   // Address on later falling strobe, data on earlier rising strobe
   always @(posedge we_act) wa <= {addr_pin[7:0], a_m1};
   always @(negedge we_act) begin
      if (byte_b)
         mem[wa[8:1]] <= dq_in;
      else if (wa[0])
         mem[wa[8:1]][15:8] <= dq_in[7:0];
      else
         mem[wa[8:1]][7:0] <= dq_in[7:0];
   end
   // Protect and unprotect on elevated levels
   always @(posedge core_clk) begin
      if (!chip_sel_b && out_en_elevated && a9_elevated && !chip_sel_elevated)
         prot[addr_pin[17:12]] <= 1'b1;
      else if (chip_sel_elevated && out_en_elevated && a9_elevated)
         for (int i = 0; i < 64; i++) prot[i] <= 1'b0;
   end
   // No embedded algorithm runs here, so reads never see status data
   // Read source: identification space or array
   always_comb begin
      if (a9_elevated)
         case (addr_pin[7:0])
            8'h00:   rd = MAKER_CODE;
            8'h01:   rd = PART_CODE;
            8'h02:   rd = {15'h0000, prot[addr_pin[17:12]]};
            default: rd = 16'h0000;
         endcase
      else if (byte_b)
         rd = mem[addr_pin[7:0]];
      else
         rd = {8'h00, a_m1 ? mem[addr_pin[7:0]][15:8] : mem[addr_pin[7:0]][7:0]};
   end
   assign dev_oe = !rd_act ? 16'h0000 : (byte_b ? 16'hffff : 16'h00ff);
   assign dq_in = (dq_oe & dq_out) | (~dq_oe & dev_oe & rd) | (~dq_oe & ~dev_oe & flt);
endmodule

// File: bench/tb.sv
`timescale 1ns/10ps
module tb;
   logic core_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_byte_mode = 1'b0;
   logic [2:0] req_op = 3'h0;
   logic [18:0] req_addr = 19'h00000;
   logic [15:0] req_wdata = 16'h0000, rsp_rdata, dq_out, dq_oe, dq_in, got;
   logic req_ready, rsp_valid, rsp_protected, chip_sel_b, out_en_b, wr_en_b, reset_b, byte_b;
   logic a9_e, cs_e, oe_e, rst_e;
   logic [3:0] rsp_sector;
   logic [17:0] addr_pin;
   int errors = 0, cmp_count = 0, n, rst_low = 0;

   always #4 core_clk = ~core_clk;
   // Counts clocks with the device held in reset, for the reset-pulse check
   always @(posedge core_clk) if (rst_b && !reset_b) rst_low <= rst_low + 1;
   flash_host u_flash_host (.core_clk(core_clk), .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_byte_mode(req_byte_mode), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_sector(rsp_sector), .rsp_protected(rsp_protected),
      .addr_pin(addr_pin), .chip_sel_b(chip_sel_b), .out_en_b(out_en_b), .wr_en_b(wr_en_b),
      .reset_b(reset_b), .byte_b(byte_b), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in),
      .a9_elevated(a9_e), .chip_sel_elevated(cs_e), .out_en_elevated(oe_e), .reset_elevated(rst_e));
   flash_dev_model u_flash_dev_model (.core_clk(core_clk), .addr_pin(addr_pin), .chip_sel_b(chip_sel_b),
      .out_en_b(out_en_b), .wr_en_b(wr_en_b), .reset_b(reset_b), .byte_b(byte_b), .dq_out(dq_out),
      .dq_oe(dq_oe), .a9_elevated(a9_e), .chip_sel_elevated(cs_e), .out_en_elevated(oe_e),
      .reset_elevated(rst_e), .dq_in(dq_in));

   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One request, held until taken, then wait for the answer
   task automatic do_op(input logic [2:0] op, input logic [18:0] a, input logic [15:0] d, input logic bm);
      @(posedge core_clk);
      req_valid <= 1'b1;
      req_op <= op;
      req_addr <= a;
      req_wdata <= d;
      req_byte_mode <= bm;
      n = 0;
      do begin @(posedge core_clk); n++; end while (req_ready !== 1'b1 && n < 60);
      req_valid <= 1'b0;
      if (n >= 60) errors++;
      n = 0;
      do begin @(posedge core_clk); n++; end while (rsp_valid !== 1'b1 && n < 60);
      if (n >= 60) errors++;
      got = rsp_rdata;
   endtask
   // Word write, byte overwrite of the high byte, word read-back
   task automatic t_rw;
      do_op(flash_host_pkg::OP_WRITE, 19'h00040, 16'h1234, 1'b0);
      do_op(flash_host_pkg::OP_READ, 19'h00040, 16'h0000, 1'b0);
      chk(got, 16'h1234);
      do_op(flash_host_pkg::OP_WRITE, 19'h00041, 16'h005a, 1'b1);
      do_op(flash_host_pkg::OP_READ, 19'h00041, 16'h0000, 1'b1);
      chk({8'h00, got[7:0]}, 16'h005a);
      do_op(flash_host_pkg::OP_READ, 19'h00040, 16'h0000, 1'b0);
      chk(got, 16'h5a34);
   endtask
   // Sector decode across the top-boot map boundaries
   task automatic t_sect;
      logic [17:0] wa [6] = '{18'h00000, 18'h30000, 18'h38000, 18'h3c000, 18'h3d000, 18'h3e000};
      logic [3:0]  es [6] = '{4'h0, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};
      logic [17:0] bw [6] = '{18'h00000, 18'h02000, 18'h03000, 18'h04000, 18'h08000, 18'h38000};
      logic [3:0]  bs [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'ha};
      for (int i = 0; i < 6; i++) begin
         do_op(flash_host_pkg::OP_READ, {wa[i], 1'b0}, 16'h0000, 1'b0);
         chk(16'(rsp_sector), 16'(es[i]));
         chk(16'(flash_host_pkg::sector_of(bw[i], 1'b0)), 16'(bs[i]));
      end
   endtask
   // Identification codes, protect, verify, unprotect
   task automatic t_id;
      do_op(flash_host_pkg::OP_ID_READ, 19'h00000, 16'h0000, 1'b0);
      chk(got, 16'h00c5);
      do_op(flash_host_pkg::OP_ID_READ, 19'h00002, 16'h0000, 1'b0);
      chk(got, 16'h3a5c);
      do_op(flash_host_pkg::OP_PROTECT, 19'h7a000, 16'h0000, 1'b0);
      do_op(flash_host_pkg::OP_ID_READ, 19'h7a004, 16'h0000, 1'b0);
      chk({8'h00, got[7:0]}, 16'h0001);
      chk(16'(rsp_protected), 16'h0001);
      do_op(flash_host_pkg::OP_ID_READ, 19'h78004, 16'h0000, 1'b0);
      chk({8'h00, got[7:0]}, 16'h0000);
      chk(16'(rsp_protected), 16'h0000);
      do_op(flash_host_pkg::OP_UNPROTECT, 19'h00000, 16'h0000, 1'b0);
      do_op(flash_host_pkg::OP_ID_READ, 19'h7a004, 16'h0000, 1'b0);
      chk({8'h00, got[7:0]}, 16'h0000);
   endtask
   // Software-requested reset pulses the device reset line, array still readable
   // Device reset must stay low for the whole setup, pulse and hold span
   task automatic t_reset;
      int          base;
      logic [15:0] span;
      span = 16'(flash_host_pkg::SETUP_CYC + flash_host_pkg::PULSE_CYC + flash_host_pkg::HOLD_CYC);
      base = rst_low;
      do_op(flash_host_pkg::OP_RESET, 19'h00000, 16'h0000, 1'b0);
      @(posedge core_clk);
      chk(16'(rst_low - base), span);
      do_op(flash_host_pkg::OP_READ, 19'h00040, 16'h0000, 1'b0);
      chk(got, 16'h5a34);
   endtask

   task automatic test_done;
      $display("Comparisons %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   initial begin
      repeat (19) @(posedge core_clk);
      chk({chip_sel_b, wr_en_b, reset_b, out_en_b, rst_e, 11'h000}, 16'hd000);
      chk(dq_oe, 16'h0000);
      @(posedge core_clk);
      rst_b <= 1'b1;
      t_rw();
      t_sect();
      t_id();
      t_reset();
      test_done();
   end
   initial begin
      #200000;
      errors++;
      test_done();
   end
endmodule
